// File: design/psw_cfg.svh
// Field positions, masks and reset values of the status word controls.
// Assumes nothing; included by the package and the design modules.
`ifndef PSW_CFG_SVH
`define PSW_CFG_SVH
`define PSW_XLEN      64
`define PSW_W         34
`define PSW_UP        2
`define PSW_SP        20
`define PSW_PP        21
`define PSW_DI        22
`define PSW_SI        23
`define PSW_DB        24
`define PSW_LP        25
`define PSW_TB        26
`define PSW_RT        27
`define PSW_RV_LO     28
`define PSW_RV_HI     31
`define PSW_CPL_LO    32
`define PSW_CPL_HI    33
`define PSW_CPL_MOST  2'h0
`define PSW_IMPL_MASK 34'h3_0FF0_0004
`define PSW_UM_MASK   34'h0_0000_0004
`define PSW_SM_MASK   34'h0_00FF_FFFF
`define PSW_LM_MASK   34'h0_FFFF_FFFF
`define PSW_CPL_MASK  34'h3_0000_0000
`define PSW_INT_KEEP  34'h0_0800_0004
`define PSW_PP_MASK   34'h0_0020_0000
`define PSW_RST_WORD  34'h0_0000_0000
`endif

// File: design/psw_chk.sv
// Combinational fault and trap decisions from the status word fields.
// Assumes the caller registers every result before it leaves the block.
`timescale 1ns/1ps
`include "psw_cfg.svh"
module psw_chk (
  psw_chk_if.chk c
);
  wire [1:0] cpl;
  wire       nonpriv;
  wire       native;
  // Field views
  assign cpl     = c.word[`PSW_CPL_HI:`PSW_CPL_LO];
  assign nonpriv = cpl != `PSW_CPL_MOST;
  assign native  = ~c.legacy;
  // Monitor and counter read protection
  assign c.gp_flt = (c.pmc_rd & nonpriv &
                     (c.word[`PSW_SP] | ~c.pce)) |
                    (c.tsc_rd & nonpriv &
                     (c.word[`PSW_SI] | c.tsd));
  assign c.preg_flt = c.itc_rd & nonpriv & c.word[`PSW_SI];
  assign c.itc_ok   = c.itc_rd & ~(nonpriv & c.word[`PSW_SI]);
  assign c.mon_cnt  = c.mon_evt & c.word[`PSW_PP];
  // Instruction set switching; system switches are never blocked
  assign c.isa_flt = c.isa_req & c.word[`PSW_DI];
  assign c.isa_ok  = (c.isa_req & ~c.word[`PSW_DI]) | c.isa_sys;
  // Address breakpoints, native and legacy forms
  assign c.idbg_flt = c.ibp & c.word[`PSW_DB] & native;
  assign c.ddbg_flt = c.dbp & c.word[`PSW_DB] & native;
  assign c.ldbg_flt = c.ibp & c.word[`PSW_DB] & c.legacy;
  // Legacy debug trap collects data breakpoints and taken branches
  assign c.ldbg_trap = (c.dbp & c.word[`PSW_DB] & c.legacy) |
                       (c.br_taken & c.br_ok & c.word[`PSW_TB] &
                        c.legacy);
  // Branch traps; rfi and interruptions come in with br_ok low
  assign c.lpt_trap = c.br_taken & c.br_ok & native &
                      c.word[`PSW_LP] & (c.br_cpl > cpl);
  assign c.tbr_trap = c.br_taken & c.br_ok & native &
                      c.word[`PSW_TB];
  // Register stack: off in legacy mode, data translation not consulted
  assign c.stk_en = native;
  assign c.stk_xl = native & c.word[`PSW_RT];
endmodule

// File: design/psw_chk_if.sv
// Carrier between the status word register and its check logic.
// Assumes both ends run on one clock; holds no state of its own.
`timescale 1ns/1ps
interface psw_chk_if;
  psw_pkg::psw_word_t word;
  logic       legacy;
  logic       pce;
  logic       tsd;
  logic       pmc_rd;
  logic       itc_rd;
  logic       tsc_rd;
  logic       isa_req;
  logic       isa_sys;
  logic       ibp;
  logic       dbp;
  logic       br_taken;
  logic       br_ok;
  logic [1:0] br_cpl;
  logic       mon_evt;
  logic       gp_flt;
  logic       isa_flt;
  logic       isa_ok;
  logic       preg_flt;
  logic       itc_ok;
  logic       idbg_flt;
  logic       ddbg_flt;
  logic       ldbg_flt;
  logic       ldbg_trap;
  logic       lpt_trap;
  logic       tbr_trap;
  logic       mon_cnt;
  logic       stk_xl;
  logic       stk_en;
  modport ctl (output word, legacy, pce, tsd, pmc_rd, itc_rd, tsc_rd,
               isa_req, isa_sys, ibp, dbp, br_taken, br_ok, br_cpl,
               mon_evt,
               input gp_flt, isa_flt, isa_ok, preg_flt, itc_ok,
               idbg_flt, ddbg_flt, ldbg_flt, ldbg_trap, lpt_trap,
               tbr_trap, mon_cnt, stk_xl, stk_en);
  modport chk (input word, legacy, pce, tsd, pmc_rd, itc_rd, tsc_rd,
               isa_req, isa_sys, ibp, dbp, br_taken, br_ok, br_cpl,
               mon_evt,
               output gp_flt, isa_flt, isa_ok, preg_flt, itc_ok,
               idbg_flt, ddbg_flt, ldbg_flt, ldbg_trap, lpt_trap,
               tbr_trap, mon_cnt, stk_xl, stk_en);
endinterface

// File: design/psw_ctrl.sv
// Status word upper controls: bits 33 to 20 plus the user monitor bit.
// Assumes ops, events and hits arrive one cycle wide from the pipeline.
`timescale 1ns/1ps
`include "psw_cfg.svh"
module psw_ctrl (
  input  wire logic                 sys_clk_i,
  input  wire logic                 reset_i,
  input  wire logic                 op_valid_i,
  input  wire psw_pkg::psw_op_t     op_kind_i,
  input  wire logic [`PSW_XLEN-1:0] op_data_i,
  input  wire logic                 interruption_i,
  input  wire logic                 default_monitor_enable_i,
  input  wire logic                 legacy_mode_i,
  input  wire logic                 legacy_counter_read_permit_i,
  input  wire logic                 legacy_timestamp_disable_i,
  input  wire logic                 perfmon_read_legacy_i,
  input  wire logic                 interval_counter_read_i,
  input  wire logic                 timestamp_read_legacy_i,
  input  wire logic                 isa_switch_req_i,
  input  wire logic                 inst_bp_hit_i,
  input  wire logic                 data_bp_hit_i,
  input  wire logic                 branch_taken_i,
  input  wire logic [1:0]           branch_target_level_i,
  input  wire logic                 priv_monitor_event_i,
  output logic [`PSW_XLEN-1:0]      processor_status_word_o,
  output logic                      gp_fault_o,
  output logic                      isa_switch_fault_o,
  output logic                      isa_switch_grant_o,
  output logic                      priv_reg_fault_o,
  output logic                      interval_counter_read_ok_o,
  output logic                      inst_debug_fault_o,
  output logic                      data_debug_fault_o,
  output logic                      legacy_debug_fault_o,
  output logic                      legacy_debug_trap_o,
  output logic                      lower_priv_trap_o,
  output logic                      taken_branch_trap_o,
  output logic                      priv_monitor_count_o,
  output logic                      stack_xlate_o,
  output logic                      stack_enable_o,
  output logic                      privileged_o
);

  // ****************************************************************
  // Operation decode
  // ****************************************************************

  psw_pkg::psw_word_t word_q;
  psw_pkg::psw_word_t word_d;
  psw_pkg::psw_word_t data_w;
  psw_pkg::psw_word_t um_bits;
  psw_pkg::psw_word_t sm_bits;
  psw_pkg::psw_word_t lm_bits;
  psw_pkg::psw_word_t lvl_word;
  psw_pkg::psw_word_t op_word;
  psw_pkg::psw_word_t int_word;
  psw_pkg::psw_word_t pp_word;
  logic op_go;
  logic is_um_set;
  logic is_um_rst;
  logic is_sm_set;
  logic is_sm_rst;
  logic is_mov_l;
  logic is_rfi;
  logic is_lvl;
  logic um_ok;

  // Legacy code cannot issue native status word ops at all
  assign op_go     = op_valid_i & ~legacy_mode_i;
  assign is_um_set = op_go & (op_kind_i == psw_pkg::PSW_OP_UM_SET);
  assign is_um_rst = op_go & (op_kind_i == psw_pkg::PSW_OP_UM_RST);
  assign is_sm_set = op_go & (op_kind_i == psw_pkg::PSW_OP_SM_SET);
  assign is_sm_rst = op_go & (op_kind_i == psw_pkg::PSW_OP_SM_RST);
  assign is_mov_l  = op_go & (op_kind_i == psw_pkg::PSW_OP_MOV_L);
  assign is_rfi    = op_go & (op_kind_i == psw_pkg::PSW_OP_RFI);
  assign is_lvl    = op_go & ((op_kind_i == psw_pkg::PSW_OP_EPC) |
                              (op_kind_i == psw_pkg::PSW_OP_BRANCH_RETURN));

  // Operand slices; reserved and foreign bits are masked away early
  assign data_w  = op_data_i[`PSW_W-1:0] & `PSW_IMPL_MASK;
  assign um_bits = data_w & `PSW_UM_MASK;
  assign sm_bits = data_w & `PSW_SM_MASK;
  assign lm_bits = data_w & `PSW_LM_MASK;
  assign um_ok   = ~word_q[`PSW_SP];

  // ****************************************************************
  // Next value selection
  // ****************************************************************

  // Level writes touch only the level field
  assign lvl_word = (word_q & ~`PSW_CPL_MASK) |
                    (data_w & `PSW_CPL_MASK);

  // Mask ops cannot reach the level field by construction of the masks
  assign op_word =
    is_um_set ? (um_ok ? (word_q | um_bits) : word_q) :
    is_um_rst ? (um_ok ? (word_q & ~um_bits) : word_q) :
    is_sm_set ? (word_q | sm_bits) :
    is_sm_rst ? (word_q & ~sm_bits) :
    is_mov_l  ? ((word_q & ~`PSW_LM_MASK) | lm_bits) :
    is_rfi    ? data_w :
    is_lvl    ? lvl_word :
    word_q;

  // Interruption keeps stack translation, reloads monitor default
  assign pp_word  = default_monitor_enable_i ? `PSW_PP_MASK
                                              : `PSW_RST_WORD;
  assign int_word = (word_q & `PSW_INT_KEEP) | pp_word;

  // Interruption outranks any op issued in the same cycle
  assign word_d = (interruption_i ? int_word : op_word) &
                  `PSW_IMPL_MASK;

  // ****************************************************************
  // Status word register
  // ****************************************************************

  // Software writes are taken at once; no serialisation modelled here
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      word_q <= `PSW_RST_WORD;
    end else begin
      word_q <= word_d;
    end
  end

  // ****************************************************************
  // Check logic hookup
  // ****************************************************************

  psw_chk_if chk_bus ();

  // Branch traps skip rfi and interruptions, which also redirect flow
  assign chk_bus.word     = word_q;
  assign chk_bus.legacy   = legacy_mode_i;
  assign chk_bus.pce      = legacy_counter_read_permit_i;
  assign chk_bus.tsd      = legacy_timestamp_disable_i;
  assign chk_bus.pmc_rd   = perfmon_read_legacy_i;
  assign chk_bus.itc_rd   = interval_counter_read_i;
  assign chk_bus.tsc_rd   = timestamp_read_legacy_i;
  assign chk_bus.isa_req  = isa_switch_req_i;
  assign chk_bus.isa_sys  = interruption_i | is_rfi;
  assign chk_bus.ibp      = inst_bp_hit_i;
  assign chk_bus.dbp      = data_bp_hit_i;
  assign chk_bus.br_taken = branch_taken_i;
  assign chk_bus.br_ok    = ~interruption_i & ~is_rfi;
  assign chk_bus.br_cpl   = branch_target_level_i;
  assign chk_bus.mon_evt  = priv_monitor_event_i;

  psw_chk u_chk (
    .c (chk_bus.chk)
  );

  // ****************************************************************
  // Registered outputs
  // ****************************************************************

  // Every result leaves one cycle after its cause, from a flop
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      gp_fault_o                 <= 1'b0;
      isa_switch_fault_o         <= 1'b0;
      isa_switch_grant_o         <= 1'b0;
      priv_reg_fault_o           <= 1'b0;
      interval_counter_read_ok_o <= 1'b0;
      inst_debug_fault_o         <= 1'b0;
      data_debug_fault_o         <= 1'b0;
      legacy_debug_fault_o       <= 1'b0;
      legacy_debug_trap_o        <= 1'b0;
      lower_priv_trap_o          <= 1'b0;
      taken_branch_trap_o        <= 1'b0;
      priv_monitor_count_o       <= 1'b0;
      stack_xlate_o              <= 1'b0;
      stack_enable_o             <= 1'b0;
      privileged_o               <= 1'b0;
    end else begin
      gp_fault_o                 <= chk_bus.gp_flt;
      isa_switch_fault_o         <= chk_bus.isa_flt;
      isa_switch_grant_o         <= chk_bus.isa_ok;
      priv_reg_fault_o           <= chk_bus.preg_flt;
      interval_counter_read_ok_o <= chk_bus.itc_ok;
      inst_debug_fault_o         <= chk_bus.idbg_flt;
      data_debug_fault_o         <= chk_bus.ddbg_flt;
      legacy_debug_fault_o       <= chk_bus.ldbg_flt;
      legacy_debug_trap_o        <= chk_bus.ldbg_trap;
      lower_priv_trap_o          <= chk_bus.lpt_trap;
      taken_branch_trap_o        <= chk_bus.tbr_trap;
      priv_monitor_count_o       <= chk_bus.mon_cnt;
      stack_xlate_o              <= chk_bus.stk_xl;
      stack_enable_o             <= chk_bus.stk_en;
      privileged_o               <= word_d[`PSW_CPL_HI:`PSW_CPL_LO] ==
                                    `PSW_CPL_MOST;
    end
  end

  // Bits 63 to 34 of the word are outside this block and read zero
  assign processor_status_word_o = {{(`PSW_XLEN-`PSW_W){1'b0}}, word_q};

  // ****************************************************************
  // Assertions
  // ****************************************************************

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  logic [1:0] cpl_now;
  assign cpl_now = word_q[`PSW_CPL_HI:`PSW_CPL_LO];

  sequence s_int;
    interruption_i;
  endsequence

  sequence s_um_op;
    (is_um_set | is_um_rst) & ~interruption_i;
  endsequence

  // A branch that may trap: native, not displaced by rfi or interruption
  sequence s_native_br;
    branch_taken_i & ~legacy_mode_i & ~interruption_i & ~is_rfi;
  endsequence

  um_lock_a: assert property (
    s_um_op ##0 word_q[`PSW_SP] |=> $stable(word_q[`PSW_UP]))
    else $error("user monitor bit changed while secured");

  um_open_a: assert property (
    s_um_op ##0 ~word_q[`PSW_SP] ##0 is_um_set ##0 op_data_i[`PSW_UP]
    |=> word_q[`PSW_UP])
    else $error("user mask set ignored while open");

  pmc_gp_a: assert property (
    perfmon_read_legacy_i & (cpl_now != `PSW_CPL_MOST) &
    (word_q[`PSW_SP] | ~legacy_counter_read_permit_i) |=> gp_fault_o)
    else $error("secured monitor read without fault");

  mon_gate_a: assert property (
    priv_monitor_event_i |=> priv_monitor_count_o == $past(word_q[`PSW_PP]))
    else $error("privileged monitor count not gated");

  isa_block_a: assert property (
    isa_switch_req_i & word_q[`PSW_DI] & ~interruption_i & ~is_rfi
    |=> isa_switch_fault_o & ~isa_switch_grant_o)
    else $error("blocked set switch not faulted");

  isa_sys_a: assert property (
    s_int |=> isa_switch_grant_o)
    else $error("interruption set switch refused");

  itc_lock_a: assert property (
    interval_counter_read_i |=> priv_reg_fault_o != interval_counter_read_ok_o)
    else $error("counter read both refused and granted");

  tsc_gp_a: assert property (
    timestamp_read_legacy_i & (cpl_now != `PSW_CPL_MOST) &
    (word_q[`PSW_SI] | legacy_timestamp_disable_i) |=> gp_fault_o)
    else $error("secured timestamp read without fault");

  bp_off_a: assert property (
    ~word_q[`PSW_DB] |=> ~inst_debug_fault_o & ~data_debug_fault_o &
    ~legacy_debug_fault_o & (~legacy_debug_trap_o | $past(branch_taken_i)))
    else $error("breakpoint raised while disabled");

  lpt_a: assert property (
    branch_taken_i & ~legacy_mode_i & word_q[`PSW_LP] & ~interruption_i &
    ~is_rfi & (branch_target_level_i > cpl_now) |=> lower_priv_trap_o)
    else $error("privilege drop not trapped");

  tb_skip_a: assert property (
    (s_int or is_rfi) |=> ~taken_branch_trap_o)
    else $error("taken branch trap from return or interruption");

  lvl_hold_a: assert property (
    ~interruption_i & ~is_rfi & ~is_lvl |=> $stable(cpl_now))
    else $error("level changed by a foreign op");

  int_state_a: assert property (
    s_int |=> (cpl_now == `PSW_CPL_MOST) & ~word_q[`PSW_DB] &
    (word_q[`PSW_RT] == $past(word_q[`PSW_RT])) &
    (word_q[`PSW_PP] == $past(default_monitor_enable_i)))
    else $error("interruption state wrong");

  stk_off_a: assert property (
    legacy_mode_i |=> ~stack_enable_o & ~stack_xlate_o)
    else $error("register stack active in legacy mode");

  tb_take_a: assert property (
    s_native_br ##0 word_q[`PSW_TB] |=> taken_branch_trap_o)
    else $error("taken branch not trapped");

  isa_open_a: assert property (
    isa_switch_req_i & ~word_q[`PSW_DI] |=> ~isa_switch_fault_o &
    isa_switch_grant_o)
    else $error("open set switch refused");

  dbg_native_a: assert property (
    word_q[`PSW_DB] & ~legacy_mode_i & (inst_bp_hit_i | data_bp_hit_i)
    |=> (inst_debug_fault_o == $past(inst_bp_hit_i)) &
    (data_debug_fault_o == $past(data_bp_hit_i)))
    else $error("native breakpoint not raised");

  leg_ifault_a: assert property (
    inst_bp_hit_i & word_q[`PSW_DB] & legacy_mode_i
    |=> legacy_debug_fault_o & ~inst_debug_fault_o)
    else $error("legacy instruction breakpoint not faulted");

  leg_dtrap_a: assert property (
    data_bp_hit_i & word_q[`PSW_DB] & legacy_mode_i
    |=> legacy_debug_trap_o & ~data_debug_fault_o)
    else $error("legacy data breakpoint not trapped");

  leg_btrap_a: assert property (
    branch_taken_i & legacy_mode_i & word_q[`PSW_TB] & ~interruption_i
    |=> legacy_debug_trap_o & ~taken_branch_trap_o)
    else $error("legacy taken branch not trapped");

  // Translation output lags the word by one cycle; privileged_o does not, it comes from word_d
  stk_xlate_a: assert property (
    ~legacy_mode_i |=> stack_enable_o &
    (stack_xlate_o == $past(word_q[`PSW_RT])))
    else $error("register stack translation not followed");

  lvl_flag_a: assert property (
    1'b1 |=> privileged_o == (cpl_now == `PSW_CPL_MOST))
    else $error("privileged flag disagrees with level");

  rsvd_zero_a: assert property (
    processor_status_word_o[`PSW_RV_HI:`PSW_RV_LO] == 4'h0)
    else $error("reserved bits not zero");

endmodule

// File: design/psw_pkg.sv
// Types shared by the status word control modules.
// Assumes psw_cfg.svh is on the include path.
`include "psw_cfg.svh"
package psw_pkg;
  // Implemented slice of the status word, bits 33 down to 0
  typedef logic [`PSW_W-1:0] psw_word_t;
  // Status word update operations seen by this block
  typedef enum logic [3:0] {
    PSW_OP_NONE   = 4'h0,
    PSW_OP_UM_SET = 4'h1,
    PSW_OP_UM_RST = 4'h2,
    PSW_OP_SM_SET = 4'h3,
    PSW_OP_SM_RST = 4'h4,
    PSW_OP_MOV_L  = 4'h5,
    PSW_OP_RFI    = 4'h6,
    PSW_OP_EPC    = 4'h7,
    PSW_OP_BRANCH_RETURN = 4'h8
  } psw_op_t;
endpackage

// File: tb/test_psw_ctrl.sv
// Self-checking bench for the status word upper controls.
// Assumes the design files and psw_cfg.svh are on the include path.
`timescale 1ns/1ps
`include "psw_cfg.svh"
module test_psw_ctrl;
  // ****************************************************
  // Stimulus, outputs and model state
  // ****************************************************
  logic             clk = 1'h0;
  logic             rst = 1'h1;
  logic             opv = 1'h0;
  psw_pkg::psw_op_t kind = psw_pkg::PSW_OP_NONE;
  logic [63:0]      data = 64'h0;
  logic             intr = 1'h0, dme = 1'h0, leg = 1'h0, pce = 1'h0;
  logic             tsd = 1'h0, pmr = 1'h0, icr = 1'h0, tsr = 1'h0;
  logic             isr = 1'h0, ibp = 1'h0, dbp = 1'h0, br = 1'h0;
  logic [1:0]       tgt = 2'h0;
  logic             evt = 1'h0;
  logic [63:0]      psw;
  logic             gp, isf, isg, prf, iok, idf, ddf, ldf;
  logic             ldt, lpt, tbt, pmc, sx, se, pv;
  logic [33:0]      w = 34'h0;
  logic [33:0]      nw;
  logic [14:0]      ex;
  int               err_total = 0;
  int               compares = 0;

  psw_ctrl psw_ctrl_inst (
    .sys_clk_i                    (clk),
    .reset_i                      (rst),
    .op_valid_i                   (opv),
    .op_kind_i                    (kind),
    .op_data_i                    (data),
    .interruption_i               (intr),
    .default_monitor_enable_i     (dme),
    .legacy_mode_i                (leg),
    .legacy_counter_read_permit_i (pce),
    .legacy_timestamp_disable_i   (tsd),
    .perfmon_read_legacy_i        (pmr),
    .interval_counter_read_i      (icr),
    .timestamp_read_legacy_i      (tsr),
    .isa_switch_req_i             (isr),
    .inst_bp_hit_i                (ibp),
    .data_bp_hit_i                (dbp),
    .branch_taken_i               (br),
    .branch_target_level_i        (tgt),
    .priv_monitor_event_i         (evt),
    .processor_status_word_o      (psw),
    .gp_fault_o                   (gp),
    .isa_switch_fault_o           (isf),
    .isa_switch_grant_o           (isg),
    .priv_reg_fault_o             (prf),
    .interval_counter_read_ok_o   (iok),
    .inst_debug_fault_o           (idf),
    .data_debug_fault_o           (ddf),
    .legacy_debug_fault_o         (ldf),
    .legacy_debug_trap_o          (ldt),
    .lower_priv_trap_o            (lpt),
    .taken_branch_trap_o          (tbt),
    .priv_monitor_count_o         (pmc),
    .stack_xlate_o                (sx),
    .stack_enable_o               (se),
    .privileged_o                 (pv)
  );

  // 125 MHz clock
  initial begin
    forever #4 clk = ~clk;
  end

  // ****************************************************
  // Reference model, run on the inputs seen at each edge
  // ****************************************************
  task automatic model();
    logic [1:0]  lv;
    logic        rf;
    logic        ok;
    logic [33:0] d;
    lv = w[33:32];
    d = data[33:0] & `PSW_IMPL_MASK;
    rf = opv && kind == psw_pkg::PSW_OP_RFI && !leg && !intr;
    ok = !intr && !rf;
    nw = w;
    // Interruption wins over any op in the same cycle
    if (intr) begin
      nw = (w & `PSW_INT_KEEP) | ({33'h0, dme} << `PSW_PP);
    end else if (opv && !leg) begin
      case (kind)
        psw_pkg::PSW_OP_UM_SET: if (!w[`PSW_SP]) nw[2] = w[2] | d[2];
        psw_pkg::PSW_OP_UM_RST: if (!w[`PSW_SP]) nw[2] = w[2] & ~d[2];
        psw_pkg::PSW_OP_SM_SET: nw = w | (d & `PSW_SM_MASK);
        psw_pkg::PSW_OP_SM_RST: nw = w & ~(d & `PSW_SM_MASK);
        psw_pkg::PSW_OP_MOV_L:
          nw = (w & ~`PSW_LM_MASK) | (d & `PSW_LM_MASK);
        psw_pkg::PSW_OP_RFI:    nw = d;
        psw_pkg::PSW_OP_EPC,
        psw_pkg::PSW_OP_BRANCH_RETURN: nw[33:32] = data[33:32];
        default: ;
      endcase
    end
    // Faults and traps judge the word held before this edge
    ex[0] = lv != 2'h0 && ((pmr && (w[20] || !pce)) ||
                           (tsr && (w[23] || tsd)));
    ex[1] = isr && w[22];
    ex[2] = (isr && !w[22]) || intr || rf;
    ex[3] = icr && lv != 2'h0 && w[23];
    ex[4] = icr && !ex[3];
    ex[5] = ibp && w[24] && !leg;
    ex[6] = dbp && w[24] && !leg;
    ex[7] = ibp && w[24] && leg;
    ex[8] = (dbp && w[24] && leg) || (br && w[26] && leg && ok);
    ex[9] = br && ok && !leg && w[25] && (tgt > lv);
    ex[10] = br && ok && !leg && w[26];
    ex[11] = evt && w[21];
    ex[12] = w[27] && !leg;
    ex[13] = !leg;
    ex[14] = nw[33:32] == 2'h0;
    if (rst) begin
      nw = 34'h0;
      ex = 15'h0;
    end
    w = nw;
  endtask

  // Random drive; reset is held in cycles 0 to 10 and 2000 to 2002
  task automatic drive(input int i);
    logic             on;
    logic             o;
    psw_pkg::psw_op_t k;
    on = !(i < 11 || (i >= 2000 && i < 2003));
    k = psw_pkg::psw_op_t'($urandom_range(8, 0));
    o = on && $urandom_range(2, 0) == 0;
    rst <= !on;
    opv <= o;
    kind <= k;
    data <= {$urandom, $urandom};
    intr <= on && $urandom_range(23, 0) == 0;
    dme <= 1'($urandom_range(1, 0));
    if ($urandom_range(39, 0) == 0) leg <= !leg;
    pce <= 1'($urandom_range(1, 0));
    tsd <= 1'($urandom_range(1, 0));
    pmr <= on && $urandom_range(2, 0) == 0;
    icr <= on && $urandom_range(2, 0) == 0;
    tsr <= on && $urandom_range(2, 0) == 0;
    isr <= on && $urandom_range(2, 0) == 0;
    ibp <= on && $urandom_range(2, 0) == 0;
    dbp <= on && $urandom_range(2, 0) == 0;
    br <= on && $urandom_range(2, 0) == 0;
    tgt <= 2'($urandom_range(3, 0));
    evt <= on && $urandom_range(2, 0) == 0;
  endtask

  // ****************************************************
  // Compare and report
  // ****************************************************
  task automatic cmp_word(input string n, input logic [63:0] e,
                          input logic [63:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmp_bit(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic check();
    cmp_word("word", {30'h0, w}, psw);
    cmp_bit("gp_fault", ex[0], gp);
    cmp_bit("isa_fault", ex[1], isf);
    cmp_bit("isa_grant", ex[2], isg);
    cmp_bit("preg_fault", ex[3], prf);
    cmp_bit("counter_ok", ex[4], iok);
    cmp_bit("inst_dbg", ex[5], idf);
    cmp_bit("data_dbg", ex[6], ddf);
    cmp_bit("leg_dbg_fault", ex[7], ldf);
    cmp_bit("leg_dbg_trap", ex[8], ldt);
    cmp_bit("lower_trap", ex[9], lpt);
    cmp_bit("branch_trap", ex[10], tbt);
    cmp_bit("mon_count", ex[11], pmc);
    cmp_bit("stk_xlate", ex[12], sx);
    cmp_bit("stk_enable", ex[13], se);
    cmp_bit("privileged", ex[14], pv);
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence: reset, random traffic, a second reset mid-run
  initial begin
    void'($urandom(84));
    for (int i = 0; i < 4000; i++) begin
      @(posedge clk);
      model();
      drive(i);
      @(negedge clk);
      check();
    end
    end_of_test();
  end
endmodule
